/* flash_pin_pkg.sv */
// constants shared by the serial flash pin interface
package flash_pin_pkg;
  localparam int PAGE_BYTES_STD = 512;
  localparam int PAGE_BYTES_ALT = 528;
  localparam int PAGE_COUNT = 4096;
  localparam int BUF_BYTES = 528;
  localparam int SEC_BYTES = 128;
  localparam int OPCODE_BITS = 8;
  localparam int ADDR_BYTES = 3;
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_TIME_NS = 2000;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam logic [7:0] CMD_READ = 8'h1B;
  localparam logic [7:0] CMD_BUF1_WR = 8'h84;
  localparam logic [7:0] CMD_BUF2_WR = 8'h87;
  localparam logic [7:0] CMD_BUF1_RD = 8'hD4;
  localparam logic [7:0] CMD_BUF2_RD = 8'hD6;
  localparam logic [7:0] CMD_BUF1_PROG = 8'h88;
  localparam logic [7:0] CMD_BUF2_PROG = 8'h89;
  localparam logic [7:0] CMD_PAGE_PROG = 8'h02;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h81;
  localparam logic [7:0] CMD_SEC_RD = 8'h77;
  localparam logic [7:0] CMD_PROT_WR = 8'h3D;
  localparam logic [7:0] SEC_ID_SEED = 8'hA5;  // arbitrary identifier seed
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  typedef enum logic [1:0] {
    CTL_IDLE = 2'b00,
    CTL_BUSY = 2'b01
  } ctl_state_t;
endpackage : flash_pin_pkg

/* serial_flash_pin_interface.sv */
// serial flash pin interface: framing, shifting, write protect, busy timer
// Overview of operation
// - select falling edge opens a command frame, rising edge closes it
// - deselected: serial output undriven, device in standby once idle
// - serial input ignored while deselected
// - input bits captured on rising serial clock edges
// - output bits launched on falling serial clock edges
// - deselect during program or erase lets it finish first
// - program and erase are timed internally on the system clock
// - write protect low guards every sector flagged in the map
// - write protect low blocks changes to the protection map
// - protected program or erase is dropped; idle after deselect
// - write protect has no internal pull-up; the pin must be driven
// - reset pin low aborts work and holds the controller idle
// - controller reset comes from the reset_i input, not power-on; no sequencing needed on reset pin
// - pages of 512 bytes, or 528 with the alternate size
// - two page-sized buffers; writes to them are ignored while array programs
// - serial modes 0 and 3 are both supported
// - one byte up to one page may program the array directly
// - 128-byte security area with unique identifier is readable
// - sequential reads run across the whole array and wrap
// - opcodes, addresses and data travel most significant bit first
`timescale 1ns/10ps
module serial_flash_pin_interface
  import flash_pin_pkg::*;
#(
  parameter int PAGES = 16,
  parameter int SECTORS = 4
) (
  input wire logic mclk_i,       // system clock
  input wire logic reset_i,      // synchronous reset, active high
  input wire logic sck_i,        // serial clock from host, link domain
  input wire logic sel_n_i,      // select, active low
  input wire logic sdi_i,        // serial input
  input wire logic wp_n_i,       // write protect, active low
  input wire logic rst_n_i,      // device reset pin, active low
  input wire logic page_alt_i,   // 1 selects 528-byte pages
  output logic sdo_o,            // serial output value
  output logic sdo_oe_o,         // serial output enable
  output logic busy_o,           // self-timed operation running
  output logic standby_o         // device deselected and idle
);
  localparam int AW = $clog2(PAGES * PAGE_BYTES_ALT);
  localparam int PW = $clog2(PAGES);
  logic [7:0] array_mem [PAGES * PAGE_BYTES_ALT];
  logic [7:0] buf_mem [2][BUF_BYTES];
  logic [SECTORS-1:0] prot_map_reg;

  function automatic logic [AW-1:0] lin_addr(input logic [23:0] a,
                                             input logic alt);
    logic [PW-1:0] pg;
    logic [9:0] by;
    if (alt) begin
      pg = a[10+PW-1:10];
      by = a[9:0];
    end else begin
      pg = a[9+PW-1:9];
      by = {1'b0, a[8:0]};
    end
    return AW'(pg * PAGE_BYTES_ALT + by);
  endfunction : lin_addr

  // byte offset inside a page or buffer; dummy bits above are dropped
  function automatic logic [9:0] byte_off(input logic [23:0] a,
                                          input logic alt);
    return alt ? a[9:0] : {1'b0, a[8:0]};
  endfunction : byte_off

  function automatic logic [9:0] page_len(input logic alt);
    return alt ? 10'(PAGE_BYTES_ALT) : 10'(PAGE_BYTES_STD);
  endfunction : page_len

  // frame reset for the link domain is select high or the reset pin low
  logic frame_rst;
  assign frame_rst = sel_n_i | ~rst_n_i;

  // rising-edge capture, msb first; mode 0 and 3 alike
  logic [5:0] bit_cnt_reg;
  logic [7:0] sh_in_reg;
  logic [7:0] opcode_reg;
  logic [23:0] addr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [9:0] wr_idx_reg;
  logic [7:0] rd_byte;
  logic [7:0] tx_reg;
  logic [7:0] cmd_op_reg;
  logic [23:0] cmd_addr_reg;
  logic [2:0] in_bits;
  assign in_bits = bit_cnt_reg[2:0];

  always_comb begin
    case (opcode_reg)
      CMD_BUF1_RD: rd_byte = buf_mem[0][rd_ptr_reg[9:0]];
      CMD_BUF2_RD: rd_byte = buf_mem[1][rd_ptr_reg[9:0]];
      CMD_SEC_RD: rd_byte = SEC_ID_SEED ^ 8'(rd_ptr_reg[6:0]);
      default: rd_byte = array_mem[rd_ptr_reg];
    endcase
  end

  always_ff @(posedge sck_i or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_reg <= '0;
      sh_in_reg <= '0;
    end else begin
      sh_in_reg <= {sh_in_reg[6:0], sdi_i};
      if (bit_cnt_reg != 6'd39) begin
        bit_cnt_reg <= bit_cnt_reg + 6'd1;
      end else begin
        bit_cnt_reg <= 6'd32;
      end
    end
  end

  // byte assembly and data phase, link domain
  logic [7:0] byte_in;
  assign byte_in = {sh_in_reg[6:0], sdi_i};
  logic in_data;
  assign in_data = bit_cnt_reg >= 6'd32;
  logic busy_sync1_reg, busy_sync2_reg;

  always_ff @(posedge sck_i or posedge frame_rst) begin
    if (frame_rst) begin
      opcode_reg <= '0;
      addr_reg <= '0;
      rd_ptr_reg <= '0;
      wr_idx_reg <= '0;
    end else if (in_bits == 3'd7) begin
      if (bit_cnt_reg == 6'd7) begin
        opcode_reg <= byte_in;
      end else if (bit_cnt_reg < 6'd32) begin
        addr_reg <= {addr_reg[15:0], byte_in};
        if (bit_cnt_reg == 6'd31) begin
          rd_ptr_reg <= (opcode_reg == CMD_SEC_RD) ? '0 :
            lin_addr({addr_reg[15:0], byte_in}, page_alt_i);
          wr_idx_reg <= byte_off({addr_reg[15:0], byte_in}, page_alt_i);
        end
      end else begin
        if (rd_ptr_reg == AW'(PAGES * PAGE_BYTES_ALT - 1)) begin
          rd_ptr_reg <= '0;
        end else begin
          rd_ptr_reg <= rd_ptr_reg + AW'(1);
        end
        if (wr_idx_reg != page_len(page_alt_i) - 10'd1) begin
          wr_idx_reg <= wr_idx_reg + 10'd1;
        end
      end
    end
  end

  // buffer and direct page fill; buffers only written while selected
  logic [7:0] page_stage [PAGE_BYTES_ALT];
  logic [9:0] stage_len_reg;
  logic [9:0] stage_lo_reg;
  always_ff @(posedge sck_i) begin
    if (!frame_rst && in_data && in_bits == 3'd7 && !busy_sync2_reg) begin
      case (opcode_reg)
        CMD_BUF1_WR: buf_mem[0][wr_idx_reg] <= byte_in;
        CMD_BUF2_WR: buf_mem[1][wr_idx_reg] <= byte_in;
        CMD_PAGE_PROG: page_stage[wr_idx_reg] <= byte_in;
        default: ;
      endcase
    end
  end
  // stage bounds must survive deselect: the self-timed copy reads them
  // afterwards, so this process has no frame reset
  always_ff @(posedge sck_i) begin
    if (!frame_rst && bit_cnt_reg == 6'd31) begin
      stage_lo_reg <= byte_off({addr_reg[15:0], byte_in}, page_alt_i);
      stage_len_reg <= byte_off({addr_reg[15:0], byte_in}, page_alt_i);
    end else if (!frame_rst && in_data && in_bits == 3'd7) begin
      stage_len_reg <= wr_idx_reg + 10'd1;
    end
  end

  // falling-edge launch, output enable only while selected
  // same edge in either clock idle level
  always_ff @(negedge sck_i or posedge frame_rst) begin
    if (frame_rst) begin
      tx_reg <= '0;
    end else if (in_data && in_bits == 3'd0) begin
      tx_reg <= rd_byte;
    end else begin
      tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  // command hand-off at deselect: the synchronised select rise carries the event
  logic sel_n_s1_reg, sel_n_s2_reg, sel_n_s3_reg;
  // no frame reset: the command must outlive deselect for the hand-off;
  // the first rise of a frame clears it so a short frame replays nothing
  always_ff @(posedge sck_i) begin
    if (!frame_rst && bit_cnt_reg == 6'd0) begin
      cmd_op_reg <= '0;
    end else if (!frame_rst && bit_cnt_reg == 6'd31) begin
      cmd_op_reg <= opcode_reg;
      cmd_addr_reg <= {addr_reg[15:0], byte_in};
    end
  end

  // system clock domain
  logic wp_s1_reg, wp_s2_reg;
  logic rst_s1_reg, rst_s2_reg;
  always_ff @(posedge mclk_i) begin
    sel_n_s1_reg <= sel_n_i;
    sel_n_s2_reg <= sel_n_s1_reg;
    sel_n_s3_reg <= sel_n_s2_reg;
    wp_s1_reg <= wp_n_i;
    wp_s2_reg <= wp_s1_reg;
    rst_s1_reg <= rst_n_i;
    rst_s2_reg <= rst_s1_reg;
  end

  logic desel_rise;
  assign desel_rise = sel_n_s2_reg & ~sel_n_s3_reg;
  logic is_write_op;
  assign is_write_op = cmd_op_reg == CMD_BUF1_PROG
    || cmd_op_reg == CMD_BUF2_PROG || cmd_op_reg == CMD_PAGE_PROG
    || cmd_op_reg == CMD_PAGE_ERASE;
  logic [PW-1:0] tgt_page;
  assign tgt_page = page_alt_i ? cmd_addr_reg[10+PW-1:10]
                               : cmd_addr_reg[9+PW-1:9];
  logic tgt_prot;
  assign tgt_prot = prot_map_reg[tgt_page / (PAGES / SECTORS)];

  ctl_state_t state_reg;
  logic [15:0] timer_reg;
  logic [PW-1:0] page_reg;
  logic [7:0] op_reg;
  logic [9:0] prog_idx_reg;
  logic accept;
  assign accept = desel_rise && is_write_op && sel_n_s2_reg
    && !(tgt_prot && !wp_s2_reg);

  always_ff @(posedge mclk_i) begin
    if (reset_i || !rst_s2_reg) begin
      state_reg <= CTL_IDLE;
      timer_reg <= '0;
      page_reg <= '0;
      op_reg <= '0;
    end else begin
      case (state_reg)
        CTL_IDLE: begin
          if (accept) begin
            state_reg <= CTL_BUSY;
            timer_reg <= 16'(PROG_CYCLES);
            page_reg <= tgt_page;
            op_reg <= cmd_op_reg;
          end
        end
        CTL_BUSY: begin
          if (timer_reg == 16'd1) begin
            state_reg <= CTL_IDLE;
          end
          timer_reg <= timer_reg - 16'd1;
        end
        default: state_reg <= CTL_IDLE;
      endcase
    end
  end

  // array update performed at the end of the self-timed cycle
  always_ff @(posedge mclk_i) begin
    if (state_reg == CTL_BUSY && timer_reg == 16'd1 && rst_s2_reg) begin
      for (int i = 0; i < PAGE_BYTES_ALT; i++) begin
        case (op_reg)
          CMD_PAGE_ERASE:
            array_mem[page_reg * PAGE_BYTES_ALT + i] <= ERASED_BYTE;
          CMD_BUF1_PROG:
            array_mem[page_reg * PAGE_BYTES_ALT + i] <= buf_mem[0][i];
          CMD_BUF2_PROG:
            array_mem[page_reg * PAGE_BYTES_ALT + i] <= buf_mem[1][i];
          CMD_PAGE_PROG: begin
            if (10'(i) >= stage_lo_reg && 10'(i) < stage_len_reg) begin
              array_mem[page_reg * PAGE_BYTES_ALT + i] <= page_stage[i];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // protection map: frozen once write protect is low
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      prot_map_reg <= '0;
    end else if (desel_rise && cmd_op_reg == CMD_PROT_WR
                 && wp_s2_reg) begin
      prot_map_reg <= cmd_addr_reg[SECTORS-1:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    busy_o <= state_reg == CTL_BUSY;
    standby_o <= sel_n_s2_reg && state_reg == CTL_IDLE;
  end

  always_ff @(posedge sck_i or posedge frame_rst) begin
    if (frame_rst) begin
      busy_sync1_reg <= 1'b0;
      busy_sync2_reg <= 1'b0;
    end else begin
      busy_sync1_reg <= state_reg == CTL_BUSY;
      busy_sync2_reg <= busy_sync1_reg;
    end
  end

  // serial output and enable are flops; enable drops with select
  always_ff @(negedge sck_i or posedge frame_rst) begin
    if (frame_rst) begin
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else begin
      sdo_o <= (in_data && in_bits == 3'd0) ? rd_byte[7] : tx_reg[6];
      sdo_oe_o <= in_data;
    end
  end

  busy_bound_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(busy_o) |-> busy_o [*8])
    else $error("busy dropped early");
  wp_block_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (desel_rise && is_write_op && tgt_prot && !wp_s2_reg
     && state_reg == CTL_IDLE) |=> state_reg == CTL_IDLE)
    else $error("protected write accepted");
  map_lock_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    !wp_s2_reg |=> $stable(prot_map_reg))
    else $error("map changed under write protect");
  rst_idle_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    !rst_s2_reg |=> state_reg == CTL_IDLE)
    else $error("reset pin did not idle controller");
  standby_wait_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    busy_o |-> !standby_o)
    else $error("standby while busy");
  oe_sel_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    sel_n_s2_reg && sel_n_s3_reg |-> !sdo_oe_o)
    else $error("output driven while deselected");
  prog_end_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_reg == CTL_BUSY && timer_reg == 16'd1 && rst_s2_reg)
    |=> state_reg == CTL_IDLE)
    else $error("self-timed cycle did not end");
  accept_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (accept && state_reg == CTL_IDLE && rst_s2_reg) |=> busy_o == 1'b0
    ##1 busy_o)
    else $error("accepted write did not start");
  // busy run is too long for a repetition, so it is counted here
  logic [7:0] busy_run_reg;
  always_ff @(posedge mclk_i) begin
    if (reset_i || !busy_o) begin
      busy_run_reg <= '0;
    end else begin
      busy_run_reg <= busy_run_reg + 8'd1;
    end
  end
  busy_len_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    $fell(busy_o) && rst_s2_reg |-> busy_run_reg == 8'(PROG_CYCLES))
    else $error("busy run length wrong");
  cov_prog_c: cover property (@(posedge mclk_i) $rose(busy_o));
  cov_rst_c: cover property (@(posedge mclk_i) busy_o && !rst_s2_reg);
  cov_wp_c: cover property (@(posedge mclk_i)
    desel_rise && is_write_op && !wp_s2_reg);
  cov_out_c: cover property (@(posedge mclk_i) sdo_oe_o);
endmodule : serial_flash_pin_interface

/* host_spi_model.sv */
// host-side serial bus model driving select, clock and data
`timescale 1ns/10ps
module host_spi_model (
  output logic sck_o,    // serial clock, runs only within frames
  output logic sel_n_o,  // select, active low
  output logic sdi_o,    // data towards the device
  input wire logic sdo_i // data from the device
);
  logic idle_hi;
  initial begin
    sck_o = 1'b0;
    sel_n_o = 1'b1;
    sdi_o = 1'b0;
    idle_hi = 1'b0;
  end
  // odd offset keeps link edges away from system clock edges
  task automatic open_frame(input logic mode3);
    #13 idle_hi = mode3;
    sck_o = mode3;
    #32 sel_n_o = 1'b0;
    #32;
  endtask : open_frame
  // data set up while the clock is low, answer taken on the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_o = 1'b0;
      sdi_o = tx[i];
      #32 sck_o = 1'b1;
      rx[i] = sdo_i;
      #32;
    end
  endtask : xfer
  task automatic close_frame();
    sck_o = idle_hi;
    #32 sel_n_o = 1'b1;
    sdi_o = ~sdi_o; // a released line does not keep its last value
  endtask : close_frame
endmodule : host_spi_model

/* serial_flash_pin_interface_test.sv */
// self-checking bench for the serial flash pin interface
`timescale 1ns/10ps
module serial_flash_pin_interface_test;
  import flash_pin_pkg::*;
  logic mclk_i, reset_i, wp_n_i, rst_n_i, page_alt_i;
  logic sck, sel_n, sdi, sdo_o, sdo_oe_o, busy_o, standby_o;
  logic [7:0] rx;
  int n_fail, compares, hi;
  serial_flash_pin_interface u_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .sck_i(sck), .sel_n_i(sel_n),
    .sdi_i(sdi), .wp_n_i(wp_n_i), .rst_n_i(rst_n_i),
    .page_alt_i(page_alt_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .busy_o(busy_o), .standby_o(standby_o));
  host_spi_model u_host (.sck_o(sck), .sel_n_o(sel_n), .sdi_o(sdi),
    .sdo_i(sdo_o));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t ns got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] op, input logic [23:0] a,
                     input logic m3);
    u_host.open_frame(m3);
    u_host.xfer(op, rx);
    for (int i = 2; i >= 0; i--) u_host.xfer(a[8*i+:8], rx);
  endtask : cmd
  task automatic done_frame();
    u_host.close_frame();
    repeat (6) @(posedge mclk_i);
  endtask : done_frame
  // counts busy cycles after deselect; standby must wait for the timer
  task automatic timed_op(input logic exp_run);
    u_host.close_frame();
    hi = 0;
    for (int i = 0; i < 200; i++) begin
      @(posedge mclk_i);
      if (busy_o === 1'b1) hi++;
      if (i == 10) chk(standby_o, !exp_run);
    end
    chk(8'(hi), exp_run ? 8'(PROG_CYCLES) : 8'h00);
    chk(standby_o, 1'b1);
  endtask : timed_op
  task automatic rd(input logic [7:0] op, input logic [23:0] a,
                    input logic [7:0] exp, input logic m3);
    cmd(op, a, m3);
    u_host.xfer(8'h00, rx);
    chk(rx, exp);
    chk(sdo_oe_o, 1'b1);
    done_frame();
    chk(sdo_oe_o, 1'b0);
  endtask : rd
  task automatic t_buf(input logic [7:0] wop, input logic [7:0] rop,
                       input logic [7:0] d, input logic m3);
    cmd(wop, 24'h00_0005, m3);
    u_host.xfer(d, rx);
    u_host.xfer(~d, rx);
    done_frame();
    rd(rop, 24'h00_0005, d, m3);
    rd(rop, 24'h00_0006, ~d, m3);
  endtask : t_buf
  task automatic t_prog();
    cmd(CMD_BUF1_PROG, 24'h00_0200, 1'b0);
    timed_op(1'b1);
    cmd(CMD_PAGE_PROG, 24'h00_0300, 1'b1);
    u_host.xfer(8'h5A, rx);
    timed_op(1'b1);
    rd(CMD_READ, 24'h00_0205, 8'hC3, 1'b0);
    rd(CMD_READ, 24'h00_0206, 8'h3C, 1'b1);
    rd(CMD_READ, 24'h00_0300, 8'h5A, 1'b0);
  endtask : t_prog
  // sector 0 holds pages 0 to 3 in the reduced model size
  task automatic t_wp();
    cmd(CMD_PROT_WR, 24'h00_0001, 1'b0);
    done_frame();
    wp_n_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    cmd(CMD_PROT_WR, 24'h00_0000, 1'b0);
    done_frame();
    cmd(CMD_PAGE_ERASE, 24'h00_0200, 1'b0);
    timed_op(1'b0);
    rd(CMD_READ, 24'h00_0205, 8'hC3, 1'b0);
    wp_n_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    cmd(CMD_PAGE_ERASE, 24'h00_0200, 1'b0);
    timed_op(1'b1);
    rd(CMD_READ, 24'h00_0205, ERASED_BYTE, 1'b0);
  endtask : t_wp
  task automatic t_rst();
    cmd(CMD_PAGE_PROG, 24'h00_0400, 1'b0);
    u_host.xfer(8'h11, rx);
    u_host.close_frame();
    repeat (8) @(posedge mclk_i);
    chk(busy_o, 1'b1);
    rst_n_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    chk(busy_o, 1'b0);
    repeat (30) @(posedge mclk_i);
    chk(busy_o, 1'b0);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    chk(standby_o, 1'b1);
  endtask : t_rst
  // offset 520 only exists with the longer page
  task automatic t_alt();
    page_alt_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    cmd(CMD_BUF2_WR, 24'h00_0208, 1'b0);
    u_host.xfer(8'h4E, rx);
    done_frame();
    rd(CMD_BUF2_RD, 24'h00_0208, 8'h4E, 1'b0);
    rd(CMD_SEC_RD, 24'h00_0000, SEC_ID_SEED, 1'b1);
    page_alt_i <= 1'b0;
  endtask : t_alt
  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  initial begin
    reset_i = 1'b1;
    wp_n_i = 1'b1;
    rst_n_i = 1'b1;
    page_alt_i = 1'b0;
    n_fail = 0;
    compares = 0;
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    chk(sdo_oe_o, 1'b0);
    chk(standby_o, 1'b1);
    t_buf(CMD_BUF1_WR, CMD_BUF1_RD, 8'hC3, 1'b0);
    t_buf(CMD_BUF2_WR, CMD_BUF2_RD, 8'h96, 1'b1);
    t_prog();
    t_wp();
    t_rst();
    t_alt();
    test_done();
  end
  // the sequence needs well under a millisecond
  initial begin
    #5_000_000;
    n_fail++;
    test_done();
  end
endmodule : serial_flash_pin_interface_test
